// ==== isq_defines.svh ====
// Timing, width and reset constants of the init, park and light sequencer
`ifndef ISQ_DEFINES_SVH
`define ISQ_DEFINES_SVH

// Reference clock rate
`define ISQ_CLK_MHZ 250
// Light source settle time after enable rises
`define ISQ_LED_DELAY_MS 100
// Mirror supply hold time after park falls
`define ISQ_MIR_HOLD_US 500
// Counter width, wide enough for the longest delay
`define ISQ_CNT_W 25
// Length of an init-done or error pulse on the status pin
`define ISQ_STAT_PULSE_CYC 8'h10
// Width of the PWM counter and duty words
`define ISQ_PWM_W 8
// Colour select value while no light source is chosen
`define ISQ_COLOR_RST 2'h0

`endif

// ==== isq_pkg.sv ====
// Types of the init, park and light sequencer
`include "isq_defines.svh"

package isq_pkg;

  localparam int ISQ_CNT_W = `ISQ_CNT_W;
  localparam int ISQ_PWM_W = `ISQ_PWM_W;

  // Initialization progress
  typedef enum logic [1:0] {ISQ_IDLE, ISQ_CFG, ISQ_DONE, ISQ_RUN} isq_init_e;

  // Colour select encoding
  typedef enum logic [1:0] {ISQ_NONE, ISQ_RED, ISQ_GREEN, ISQ_BLUE} isq_color_e;

  // Complete state of the sequencer
  typedef struct packed {
    logic por_s1;
    logic por_s2;
    logic park_s1;
    logic park_s2;
    logic led_s1;
    logic led_s2;
    isq_init_e init_st;
    logic cfg_start;
    logic [ISQ_CNT_W-1:0] led_cnt;
    logic [ISQ_CNT_W-1:0] mir_cnt;
    logic mir_en;
    logic drv_en;
    isq_color_e color;
    logic oe;
    logic sclk;
    logic mosi;
    logic cs0_n;
    logic status;
    logic [7:0] stat_cnt;
    logic err_pend;
    logic [ISQ_PWM_W-1:0] pwm_cnt;
    logic [2:0] rgb;
  } isq_state_s;

endpackage : isq_pkg

// ==== isq_sequencer.sv ====
// Power-on, park and light source sequencing of the display controller
//
// Overview of operation
// - Start self-configuration on reset pin rising edge
// - Tri-state seven outputs while reset is asserted
// - Light enable low forces driver off, colour 00
// - Enable driver and colour 100 ms after enable
// - Status pin pulses high once after initialization
// - Later errors pulse the same status pin high
// - GPIOs carry PWM, or processor bits with driver
// - Driver enable drops when light enable or park low
// - Mirror supply follows park, held 500 us after
`timescale 1ns/1ns

`include "isq_defines.svh"

module isq_sequencer #(
  parameter logic [isq_pkg::ISQ_CNT_W-1:0] LED_DELAY_CYC =
    isq_pkg::ISQ_CNT_W'(`ISQ_LED_DELAY_MS * 1000 * `ISQ_CLK_MHZ),
  parameter logic [isq_pkg::ISQ_CNT_W-1:0] MIR_HOLD_CYC =
    isq_pkg::ISQ_CNT_W'(`ISQ_MIR_HOLD_US * `ISQ_CLK_MHZ)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic por_reset_n,
  input wire logic park_n,
  input wire logic light_source_en,
  input wire logic cfg_done,
  input wire logic error_event,
  input wire logic ext_driver_present,
  input wire logic [1:0] seq_color,
  input wire logic [isq_pkg::ISQ_PWM_W-1:0] red_duty,
  input wire logic [isq_pkg::ISQ_PWM_W-1:0] green_duty,
  input wire logic [isq_pkg::ISQ_PWM_W-1:0] blue_duty,
  input wire logic [2:0] gpo_bits,
  input wire logic flash_sclk_in,
  input wire logic flash_mosi_in,
  input wire logic flash_cs0_n_in,
  output logic cfg_start,
  output logic mirror_supply_en,
  output logic mirror_supply_en_oe,
  output logic light_driver_master_en,
  output logic light_driver_master_en_oe,
  output logic color_select_bit0,
  output logic color_select_bit1,
  output logic color_select_oe,
  output logic flash_sclk,
  output logic flash_mosi,
  output logic flash_cs0_n,
  output logic flash_oe,
  output logic init_status_pin,
  output logic red_pwm_out,
  output logic green_pwm_out,
  output logic blue_pwm_out
);
  import isq_pkg::*;

  isq_state_s st_r;
  isq_state_s st_nxt;
  logic [ISQ_PWM_W-1:0] duty [3];
  logic [2:0] pwm_on;

  assign duty[0] = red_duty;
  assign duty[1] = green_duty;
  assign duty[2] = blue_duty;

  // Per-colour PWM compare against the shared counter
  for (genvar i = 0; i < 3; i++) begin : g_pwm
    assign pwm_on[i] = st_r.pwm_cnt < duty[i];
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.por_s1 = por_reset_n;
    st_nxt.por_s2 = st_r.por_s1;
    st_nxt.park_s1 = park_n; // High pin means run
    st_nxt.park_s2 = st_r.park_s1;
    st_nxt.led_s1 = light_source_en;
    st_nxt.led_s2 = st_r.led_s1;
    st_nxt.cfg_start = 1'b0;
    st_nxt.pwm_cnt = st_r.pwm_cnt + 1'b1;
    // Pins float while reset is held
    st_nxt.oe = st_r.por_s2;
    st_nxt.sclk = flash_sclk_in;
    st_nxt.mosi = flash_mosi_in;
    st_nxt.cs0_n = flash_cs0_n_in;
    // Errors in the run state are remembered until a pulse can carry them
    if (error_event && st_r.init_st == ISQ_RUN) begin
      st_nxt.err_pend = 1'b1;
    end
    // Initialization and status pulses
    case (st_r.init_st)
      ISQ_IDLE: begin
        st_nxt.status = 1'b0;
        if (st_r.por_s2 && !st_r.por_s1) begin
          st_nxt.init_st = ISQ_IDLE;
        end else if (!st_r.por_s2 && st_r.por_s1) begin
          st_nxt.init_st = ISQ_CFG;
          st_nxt.cfg_start = 1'b1;
        end
      end
      ISQ_CFG: begin
        if (cfg_done) begin
          st_nxt.init_st = ISQ_DONE;
          st_nxt.status = 1'b1;
          st_nxt.stat_cnt = `ISQ_STAT_PULSE_CYC;
        end
      end
      ISQ_DONE, ISQ_RUN: begin
        if (st_r.stat_cnt != 8'h00) begin
          st_nxt.stat_cnt = st_r.stat_cnt - 8'h01;
          st_nxt.status = st_r.stat_cnt != 8'h01;
        end else begin
          st_nxt.init_st = ISQ_RUN;
          st_nxt.status = 1'b0;
          if (st_r.err_pend && !st_r.status) begin
            st_nxt.status = 1'b1;
            st_nxt.stat_cnt = `ISQ_STAT_PULSE_CYC;
            st_nxt.err_pend = error_event;
          end
        end
      end
      default: begin
        st_nxt.init_st = ISQ_IDLE;
      end
    endcase
    // Light enable settle counter, cleared while the enable is low
    if (!st_r.led_s2) begin
      st_nxt.led_cnt = '0;
    end else if (st_r.led_cnt != LED_DELAY_CYC) begin
      st_nxt.led_cnt = st_r.led_cnt + 1'b1;
    end
    // Master enable needs settled light enable and raised park
    st_nxt.drv_en = st_r.led_s2 && st_r.park_s2 && st_r.por_s2 &&
                    st_r.led_cnt == LED_DELAY_CYC;
    st_nxt.color = st_nxt.drv_en ? isq_color_e'(seq_color) : ISQ_NONE;
    // Mirror supply follows park and lingers after it falls
    if (st_r.park_s2) begin
      st_nxt.mir_en = 1'b1;
      st_nxt.mir_cnt = '0;
    end else if (st_r.mir_en) begin
      if (st_r.mir_cnt == MIR_HOLD_CYC) begin
        st_nxt.mir_en = 1'b0;
      end else begin
        st_nxt.mir_cnt = st_r.mir_cnt + 1'b1;
      end
    end
    // PWM or processor bits; PWM is forced high while the driver is off
    st_nxt.rgb = ext_driver_present ? gpo_bits :
                 (st_nxt.drv_en ? pwm_on : 3'h7);
    // Lost reset pin restarts init, status and the driver, colour and mirror enables; a rise already in the first stage keeps its start
    if (!st_r.por_s2) begin
      st_nxt.init_st = st_r.por_s1 ? ISQ_CFG : ISQ_IDLE;
      st_nxt.cfg_start = st_r.por_s1;
      st_nxt.status = 1'b0;
      st_nxt.stat_cnt = 8'h00;
      st_nxt.err_pend = 1'b0;
      st_nxt.drv_en = 1'b0;
      st_nxt.color = ISQ_NONE;
      st_nxt.mir_en = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.color <= isq_color_e'(`ISQ_COLOR_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output map, all from the state register
  assign cfg_start = st_r.cfg_start;
  assign mirror_supply_en = st_r.mir_en;
  assign mirror_supply_en_oe = st_r.oe;
  assign light_driver_master_en = st_r.drv_en;
  assign light_driver_master_en_oe = st_r.oe;
  assign color_select_bit0 = st_r.color[0];
  assign color_select_bit1 = st_r.color[1];
  assign color_select_oe = st_r.oe;
  assign flash_sclk = st_r.sclk;
  assign flash_mosi = st_r.mosi;
  assign flash_cs0_n = st_r.cs0_n;
  assign flash_oe = st_r.oe;
  assign init_status_pin = st_r.status;
  assign red_pwm_out = st_r.rgb[0];
  assign green_pwm_out = st_r.rgb[1];
  assign blue_pwm_out = st_r.rgb[2];

  // Checks
  chk_cfg_kick: assert property (@(posedge ref_clk) disable iff (srst)
    st_r.init_st == ISQ_IDLE && st_r.por_s1 && !st_r.por_s2 |=> cfg_start)
    else $error("configuration not started on reset release");
  chk_tristate_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !st_r.por_s2 |=> !mirror_supply_en_oe && !flash_oe && !color_select_oe)
    else $error("outputs driven during reset");
  chk_light_off: assert property (@(posedge ref_clk) disable iff (srst)
    !st_r.led_s2 |=> !light_driver_master_en && !color_select_bit0 && !color_select_bit1)
    else $error("driver or colour active with light enable low");
  chk_led_delay: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(light_driver_master_en) |-> $past(st_r.led_cnt) == LED_DELAY_CYC)
    else $error("driver enabled before the settle delay");
  chk_park_drop: assert property (@(posedge ref_clk) disable iff (srst)
    !st_r.park_s2 |=> !light_driver_master_en)
    else $error("driver enable held with park low");
  chk_mirror_hold: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(mirror_supply_en) && st_r.por_s2 |-> $past(st_r.mir_cnt) == MIR_HOLD_CYC)
    else $error("mirror supply dropped early");
  chk_init_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    st_r.init_st == ISQ_CFG && cfg_done && st_r.por_s2 |=> init_status_pin [*8])
    else $error("init-done pulse missing");
  chk_err_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    error_event && st_r.init_st == ISQ_RUN && st_r.por_s2 |-> ##[1:40] init_status_pin)
    else $error("error not reported");
  chk_gpo_pass: assert property (@(posedge ref_clk) disable iff (srst)
    ext_driver_present |=> {blue_pwm_out, green_pwm_out, red_pwm_out} == $past(gpo_bits))
    else $error("general outputs not passed through");
  chk_color_gate: assert property (@(posedge ref_clk) disable iff (srst)
    (color_select_bit0 || color_select_bit1) |-> light_driver_master_en)
    else $error("colour selected with driver off");

  cov_init_done: cover property (@(posedge ref_clk) disable iff (srst)
    st_r.init_st == ISQ_DONE ##1 st_r.init_st == ISQ_RUN);
  cov_led_on: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(light_driver_master_en));
  cov_mirror_off: cover property (@(posedge ref_clk) disable iff (srst)
    $fell(mirror_supply_en) && st_r.por_s2);

endmodule : isq_sequencer

// ==== isq_host_model.sv ====
// Host and light or mirror power driver model facing the sequencer pins
`timescale 1ns/1ns

module isq_host_model (
  input wire logic ref_clk,
  input wire logic mir_val,
  input wire logic mir_oe,
  output logic por_reset_n,
  output logic park_n,
  output logic light_source_en,
  output logic mir_pin
);
  // Weak pull-down keeps the mirror supply off while the pin floats
  assign mir_pin = mir_oe ? mir_val : 1'b0;

  // Reset and park held low at power-up
  initial begin
    por_reset_n = 1'b0;
    park_n = 1'b0;
    light_source_en = 1'b0;
  end

  // Raise park first, then release reset a few cycles later
  task automatic power_up();
    @(posedge ref_clk);
    #1;
    park_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    por_reset_n = 1'b1;
  endtask : power_up

  // Reset and park both go back low after the same edge
  task automatic power_down();
    @(posedge ref_clk);
    #1;
    park_n = 1'b0;
    por_reset_n = 1'b0;
  endtask : power_down

  // Park level after the edge
  task automatic set_park(input logic v);
    @(posedge ref_clk);
    #1;
    park_n = v;
  endtask : set_park

  // Light enable level after the edge
  task automatic set_light(input logic v);
    @(posedge ref_clk);
    #1;
    light_source_en = v;
  endtask : set_light
endmodule : isq_host_model

// ==== init_park_led_sequencer_tb.sv ====
// Self-checking bench of the init, park and light sequencer
`timescale 1ns/1ns

module init_park_led_sequencer_tb;
  import isq_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_done = 1'b0;
  logic error_event = 1'b0;
  logic ext_drv = 1'b0;
  logic [1:0] seq_color = 2'h0;
  logic [2:0] gpo = 3'h5;
  logic [2:0] fl_in = 3'h0;
  wire [2:0] fl_out;
  logic [7:0] rd = 8'h80, gd = 8'h80, bd = 8'h80;
  logic por_n, park_n, led_en, mir_pin, cfg_start, mir, mir_oe, drv, drv_oe;
  logic c0, c1, c_oe, flash_oe, status, r, g, b;
  int failures = 0;
  int compares = 0;
  wire logic [7:0] obs = {status, drv, mir_pin, cfg_start, c_oe, flash_oe, mir_oe, drv_oe};

  always #2 ref_clk = ~ref_clk;

  isq_host_model u_host (.ref_clk(ref_clk), .mir_val(mir), .mir_oe(mir_oe),
    .por_reset_n(por_n), .park_n(park_n), .light_source_en(led_en), .mir_pin(mir_pin));

  isq_sequencer #(.LED_DELAY_CYC(25'h14), .MIR_HOLD_CYC(25'h0a)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .por_reset_n(por_n), .park_n(park_n),
    .light_source_en(led_en), .cfg_done(cfg_done), .error_event(error_event),
    .ext_driver_present(ext_drv), .seq_color(seq_color), .red_duty(rd), .green_duty(gd),
    .blue_duty(bd), .gpo_bits(gpo), .flash_sclk_in(fl_in[0]), .flash_mosi_in(fl_in[1]),
    .flash_cs0_n_in(fl_in[2]), .cfg_start(cfg_start), .mirror_supply_en(mir),
    .mirror_supply_en_oe(mir_oe), .light_driver_master_en(drv),
    .light_driver_master_en_oe(drv_oe), .color_select_bit0(c0), .color_select_bit1(c1),
    .color_select_oe(c_oe), .flash_sclk(fl_out[0]), .flash_mosi(fl_out[1]),
    .flash_cs0_n(fl_out[2]),
    .flash_oe(flash_oe), .init_status_pin(status), .red_pwm_out(r),
    .green_pwm_out(g), .blue_pwm_out(b));

  // Counts and verdict, the single end of the run
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  // Cycles until an observed bit reaches a level; running out ends the run
  task automatic wait_bit(input int i, input logic v, input int lim, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
      if (n > lim) begin
        check("wait bound", 8'h00, 8'h01);
        end_of_test();
      end
    end while (obs[i] !== v);
  endtask : wait_bit

  // Outputs floating in reset, start pulse, init-done pulse
  task automatic t_init();
    int n;
    check("oe in reset", 8'h00, {4'h0, obs[3:0]});
    u_host.power_up();
    wait_bit(4, 1'b1, 10, n);
    tick(2);
    check("oe after reset", 8'h0f, {4'h0, obs[3:0]});
    // Flash pins follow their engine one edge later
    fl_in = 3'h5;
    tick(1);
    check("flash pass", 8'h05, {5'h0, fl_out});
    fl_in = 3'h2;
    tick(1);
    check("flash pass", 8'h02, {5'h0, fl_out});
    cfg_done = 1'b1;
    tick(1);
    cfg_done = 1'b0;
    wait_bit(7, 1'b1, 4, n);
    wait_bit(7, 0, 30, n);
    // The cfg_done edge already carried the first high cycle
    check("init pulse", 8'h10, 8'(n + 1));
    $display("t_init done");
  endtask : t_init

  // Error pulse on the status pin
  task automatic t_error();
    int n;
    // Errors count only once the run state follows the done pulse
    tick(1);
    error_event = 1'b1;
    tick(1);
    error_event = 1'b0;
    wait_bit(7, 1'b1, 4, n);
    // Edges counted from the edge that took the event
    check("error delay", 8'h02, 8'(n + 1));
    wait_bit(7, 1'b0, 30, n);
    check("error pulse", 8'h10, 8'(n));
    $display("t_error done");
  endtask : t_error

  // Light delay, colour tracking, PWM and drop on light enable low
  task automatic t_light();
    int n, cr, cg, cb;
    u_host.set_light(1'b1);
    wait_bit(6, 1'b1, 40, n);
    check("light delay", 8'h01, 8'(n >= 21 && n <= 24));
    for (int k = 0; k < 4; k++) begin
      seq_color = 2'(k);
      tick(2);
      check("colour", 8'(k), {6'h0, c1, c0});
    end
    {rd, gd, bd} = {8'h40, 8'h00, 8'hff};
    {cr, cg, cb} = 0;
    tick(2);
    repeat (256) begin
      tick(1);
      {cr, cg, cb} = {cr + r, cg + g, cb + b};
    end
    check("pwm duty", 8'h01, 8'(cr == 64 && cg == 0 && cb == 255));
    ext_drv = 1'b1;
    tick(3);
    check("gpo bits", 8'h05, {5'h0, b, g, r});
    ext_drv = 1'b0;
    u_host.set_light(1'b0);
    wait_bit(6, 1'b0, 4, n);
    check("colour off", 8'h00, {6'h0, c1, c0});
    $display("t_light done");
  endtask : t_light

  // Park drop, mirror hold, forced PWM, then power down
  task automatic t_park();
    int n, m;
    seq_color = 2'h2;
    u_host.set_light(1'b1);
    wait_bit(6, 1'b1, 40, n);
    u_host.set_park(1'b0);
    wait_bit(6, 1'b0, 4, n);
    check("colour parked", 8'h00, {6'h0, c1, c0});
    wait_bit(5, 1'b0, 20, m);
    check("mirror hold", 8'h01, 8'(n + m >= 12 && n + m <= 16));
    check("pwm forced", 8'h07, {5'h0, b, g, r});
    u_host.power_down();
    wait_bit(2, 1'b0, 6, n);
    tick(1);
    check("oe power down", 8'h00, {4'h0, obs[3:0]});
    $display("t_park done");
  endtask : t_park

  // Reset, then the scenarios in order
  initial begin
    tick(12);
    srst = 1'b0;
    tick(2);
    t_init();
    t_error();
    t_light();
    t_park();
    end_of_test();
  end
endmodule : init_park_led_sequencer_tb
